// [common/scrb_params.svh]
`ifndef SCRB_PARAMS_SVH
`define SCRB_PARAMS_SVH

// register addresses seen from the serial host
`define SCRB_ADDR_IR_GAIN 5'h00
`define SCRB_ADDR_IR_REF 5'h01
`define SCRB_ADDR_TEMP_GAIN 5'h02
`define SCRB_ADDR_CONF 5'h03
`define SCRB_ADDR_TEST 5'h10
`define SCRB_ADDR_WP_HI 2'b11
`define SCRB_ADDR_WP_LO 3'b000

// eeprom addresses of the stored copies
`define SCRB_EE_IR_GAIN 7'h00
`define SCRB_EE_IR_REF 7'h01
`define SCRB_EE_TEMP_GAIN 7'h02
`define SCRB_EE_CONF 7'h03
`define SCRB_EE_THRESHOLD 7'h75

// unlock keys for test mode and eeprom protection
`define SCRB_TEST_KEY 16'hb200
`define SCRB_WP_KEY 16'h0065

// writable bit masks and reset values
`define SCRB_WORD_MASK 16'hffe0
`define SCRB_CONF_MASK 16'h7fc0
`define SCRB_WORD_RESET 16'h0000
`define SCRB_CONF_RESET 16'h2000

// ir chain gain word fields
`define SCRB_HALVE_BIT 15
`define SCRB_DAC_EN_BIT 14
`define SCRB_LOW_NOISE_BIT 13
`define SCRB_IR_GAIN_MSB 12
`define SCRB_IR_GAIN_LSB 5

// ir chain reference word fields
`define SCRB_GND_RSV_MSB 15
`define SCRB_GND_RSV_LSB 12
`define SCRB_DAC_REF_MSB 11
`define SCRB_DAC_REF_LSB 9
`define SCRB_GND_LVL_MSB 8
`define SCRB_GND_LVL_LSB 5

// temperature chain word fields
`define SCRB_AMB_REF_MSB 15
`define SCRB_AMB_REF_LSB 14
`define SCRB_MIRROR_MSB 13
`define SCRB_MIRROR_LSB 11
`define SCRB_TEMP_GAIN_MSB 10
`define SCRB_TEMP_GAIN_LSB 5

// general configuration word fields
`define SCRB_FATAL_BIT 15
`define SCRB_REF_STOP_BIT 14
`define SCRB_BATT_REG_BIT 13
`define SCRB_ADC_REF_BIT 12
`define SCRB_THR_SRC_BIT 11
`define SCRB_CMP_TGT_BIT 10
`define SCRB_CMP_POL_BIT 9
`define SCRB_BYPASS_BIT 8
`define SCRB_REL_TGT_BIT 7
`define SCRB_REL_POL_BIT 6
`define SCRB_WR_ALLOWED_BIT 5
`define SCRB_TEST_MODE_BIT 4

// dac reference in millivolts, base and step per code
`define SCRB_DAC_REF_BASE_MV 13'd2000
`define SCRB_DAC_REF_STEP_MV 13'd500
`define SCRB_DAC_REF_LAST 3'b101

`endif

// [common/scrb_pkg.sv]
package scrb_pkg;

  typedef logic [15:0] scrb_word_type;

  typedef enum logic [1:0] {
    SCRB_BOOT_REQ,
    SCRB_BOOT_WAIT,
    SCRB_IDLE,
    SCRB_RD_WAIT
  } scrb_state_type;

  typedef struct packed {
    scrb_word_type word;
  } scrb_word_state_type;

  typedef struct packed {
    scrb_state_type state;
    logic [2:0] boot_idx;
    logic test_mode;
    logic wr_allowed;
    logic fatal;
    logic armed;
    scrb_word_type rdata;
    logic rvalid;
    logic ee_req;
    logic ee_we;
    logic [6:0] ee_addr;
    scrb_word_type ee_wdata;
    scrb_word_type stored_threshold;
    scrb_word_type relay_threshold;
    logic [12:0] dac_ref_mv;
  } scrb_bank_state_type;

endpackage

// [logic/scrb_register_bank.sv]
// Behaviour
// - gain words read back from eeprom copy
// - live write in test mode, eeprom when also unlocked
// - configuration word readable live or eeprom anytime
// - dac regulator enable and low noise bits
// - eight bit ir gain code output
// - three bit dac reference select, 2V-4.5V
// - five bit ir ground level, msb external
// - two bit ambient reference select
// - three bit mirror ratio select
// - six bit temperature gain code
// - multi-bit eeprom error sets fatal flag
// - fatal clears after test, unlock, normal
// - reference stop bit, pin input without regulator
// - battery regulator enable resets to one
// - adc reference external or internal on ground
// - threshold from stored word or potentiometer
// - comparator target and polarity bits
// - bypass feeds temperature inputs to adc
// - relay target and polarity bits
// - write-allowed and test flags reset zero
// - flags change only through key registers
// - boot copies eeprom words into live registers
`timescale 1ns/10ps
`default_nettype none
`include "scrb_params.svh"

module scrb_register_bank #(
  parameter int EE_ADDR_W = 7
) (
  input wire logic clk_sys, // system clock
  input wire logic rst_b, // async reset, active low
  input wire logic [4:0] reg_addr, // register address
  input wire logic reg_wr, // write strobe
  input wire scrb_pkg::scrb_word_type reg_wdata, // write data
  input wire logic reg_rd, // read strobe
  input wire logic reg_rd_from_eeprom, // config read source
  output logic reg_busy, // access not accepted
  output scrb_pkg::scrb_word_type reg_rdata, // read data
  output logic reg_rvalid, // read data valid
  output logic ee_req, // eeprom request pulse
  output logic ee_we, // eeprom write
  output logic [6:0] ee_addr, // eeprom address
  output scrb_pkg::scrb_word_type ee_wdata, // eeprom write data
  input wire scrb_pkg::scrb_word_type ee_rdata, // corrected read data
  input wire logic ee_rvalid, // read data valid
  input wire logic ee_multi_err, // uncorrectable word
  input wire logic ir_ground_level_msb, // fifth ground bit
  input wire scrb_pkg::scrb_word_type pot_threshold, // potentiometer level
  output logic reference_halve_enable, // halve dac reference
  output logic dac_regulator_enable, // dac regulator on
  output logic low_noise_enable, // low noise mode
  output logic [7:0] ir_gain_code, // ir chain gain
  output logic [3:0] reserved_ground_bits, // reserved field
  output logic [2:0] dac_reference_select, // dac reference code
  output logic [12:0] dac_reference_mv, // dac reference, mV
  output logic [4:0] ir_ground_level_select, // ir ground level
  output logic [1:0] ambient_reference_select, // ambient reference
  output logic [2:0] mirror_ratio_select, // mirror ratio
  output logic [5:0] temp_gain_code, // temperature gain
  output logic internal_reference_stop, // stop dac reference
  output logic vref_pin_input, // reference pin is input
  output logic battery_regulator_enable, // battery regulator on
  output logic adc_reference_source, // 1 internal adc ref
  output logic threshold_source_select, // 1 potentiometer
  output scrb_pkg::scrb_word_type relay_threshold, // active threshold
  output logic comparator_target_select, // 1 ambient
  output logic comparator_polarity, // 1 non-inverting
  output logic temp_chain_bypass, // 1 direct inputs
  output logic relay_target_select, // 1 ambient
  output logic relay_polarity, // 1 non-inverting
  output logic eeprom_write_allowed_flag, // eeprom unlocked
  output logic test_mode_flag, // test mode active
  output logic fatal_error_flag // multi-bit eeprom fault
);
  import scrb_pkg::*;

  // refuse address widths and field layouts the decode cannot serve
  generate
    if (EE_ADDR_W != 7) begin : g_bad_addr_w
      $error("EE_ADDR_W must be 7");
    end
    if (`SCRB_IR_GAIN_MSB - `SCRB_IR_GAIN_LSB != 7) begin : g_bad_ir_gain
      $error("ir gain field must be 8 bits");
    end
    if (`SCRB_GND_RSV_MSB - `SCRB_GND_RSV_LSB != 3) begin : g_bad_gnd_rsv
      $error("reserved ground field must be 4 bits");
    end
    if (`SCRB_DAC_REF_MSB - `SCRB_DAC_REF_LSB != 2) begin : g_bad_dac_ref
      $error("dac reference field must be 3 bits");
    end
    if (`SCRB_GND_LVL_MSB - `SCRB_GND_LVL_LSB != 3) begin : g_bad_gnd_lvl
      $error("ground level field must be 4 bits");
    end
    if (`SCRB_AMB_REF_MSB - `SCRB_AMB_REF_LSB != 1) begin : g_bad_amb_ref
      $error("ambient reference field must be 2 bits");
    end
    if (`SCRB_MIRROR_MSB - `SCRB_MIRROR_LSB != 2) begin : g_bad_mirror
      $error("mirror ratio field must be 3 bits");
    end
    if (`SCRB_TEMP_GAIN_MSB - `SCRB_TEMP_GAIN_LSB != 5) begin : g_bad_temp_gain
      $error("temperature gain field must be 6 bits");
    end
    if (`SCRB_ADDR_CONF != 5'h03) begin : g_bad_conf_addr
      $error("word decode needs the four words at 00h to 03h");
    end
    if (`SCRB_ADDR_TEST <= `SCRB_ADDR_CONF) begin : g_bad_test_addr
      $error("test key register overlaps the words");
    end
    if (`SCRB_EE_THRESHOLD <= `SCRB_EE_CONF) begin : g_bad_thr_addr
      $error("stored threshold overlaps the stored words");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////

  scrb_bank_state_type r;
  scrb_bank_state_type next_r;
  scrb_word_type live [4];
  logic [3:0] load_en;
  logic [3:0] wr_en;
  scrb_word_type conf_view;
  logic err_hit;
  logic wp_addr;

  // dac reference code to millivolts, spare codes read zero
  function automatic logic [12:0] dac_mv(input logic [2:0] code);
    logic [12:0] mv;
    mv = 13'h0000;
    if (code <= `SCRB_DAC_REF_LAST) begin
      mv = 13'(`SCRB_DAC_REF_BASE_MV + `SCRB_DAC_REF_STEP_MV * {10'h000, code});
    end
    return mv;
  endfunction

  // boot order: four words then the stored threshold
  function automatic logic [6:0] boot_addr(input logic [2:0] idx);
    logic [6:0] a;
    case (idx)
      3'h0: a = `SCRB_EE_IR_GAIN;
      3'h1: a = `SCRB_EE_IR_REF;
      3'h2: a = `SCRB_EE_TEMP_GAIN;
      3'h3: a = `SCRB_EE_CONF;
      default: a = `SCRB_EE_THRESHOLD;
    endcase
    return a;
  endfunction

  ////////////////////////////////////////////////////////////////////////

  // live words, masked so flags stay out of the stored bits
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_word
      scrb_word_reg #(
        .RESET_VALUE((gi == 3) ? `SCRB_CONF_RESET : `SCRB_WORD_RESET),
        .WRITE_MASK((gi == 3) ? `SCRB_CONF_MASK : `SCRB_WORD_MASK)
      ) u_word (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .load(load_en[gi]),
        .load_data(ee_rdata),
        .wr(wr_en[gi]),
        .wr_data(reg_wdata),
        .word(live[gi])
      );
    end
  endgenerate

  // configuration word as the host sees it
  always_comb begin
    conf_view = live[3];
    conf_view[`SCRB_FATAL_BIT] = r.fatal;
    conf_view[`SCRB_WR_ALLOWED_BIT] = r.wr_allowed;
    conf_view[`SCRB_TEST_MODE_BIT] = r.test_mode;
  end

  // uncorrectable answer and write-protect key decode
  assign err_hit = ee_rvalid && ee_multi_err;
  assign wp_addr = (reg_addr[4:3] == `SCRB_ADDR_WP_HI);

  // boot loads and test mode writes into the live words
  always_comb begin
    load_en = 4'h0;
    wr_en = 4'h0;
    if (r.state == SCRB_BOOT_WAIT && ee_rvalid && r.boot_idx < 3'h4) begin
      load_en[r.boot_idx[1:0]] = 1'b1;
    end
    if (r.state == SCRB_IDLE && reg_wr && r.test_mode && reg_addr <= `SCRB_ADDR_CONF) begin
      wr_en[reg_addr[1:0]] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////

  // sequencer, key registers and flags
  always_comb begin
    next_r = r;
    next_r.rvalid = 1'b0;
    next_r.ee_req = 1'b0;
    next_r.ee_we = 1'b0;
    case (r.state)
      SCRB_BOOT_REQ: begin
        next_r.ee_req = 1'b1;
        next_r.ee_addr = boot_addr(r.boot_idx);
        next_r.state = SCRB_BOOT_WAIT;
      end
      SCRB_BOOT_WAIT: begin
        if (ee_rvalid) begin
          if (r.boot_idx == 3'h4) begin
            next_r.stored_threshold = ee_rdata;
            next_r.state = SCRB_IDLE;
          end else begin
            next_r.boot_idx = 3'(r.boot_idx + 3'h1);
            next_r.state = SCRB_BOOT_REQ;
          end
        end
      end
      SCRB_IDLE: begin
        if (reg_wr) begin
          if (reg_addr <= `SCRB_ADDR_CONF) begin
            if (r.test_mode && r.wr_allowed) begin
              next_r.ee_req = 1'b1;
              next_r.ee_we = 1'b1;
              next_r.ee_addr = {4'h0, reg_addr[2:0]};
              next_r.ee_wdata = reg_wdata;
            end
          end else if (reg_addr == `SCRB_ADDR_TEST) begin
            next_r.test_mode = (reg_wdata == `SCRB_TEST_KEY);
          end else if (wp_addr) begin
            next_r.wr_allowed = (reg_wdata == `SCRB_WP_KEY);
          end
        end else if (reg_rd) begin
          if (reg_addr < `SCRB_ADDR_CONF || (reg_addr == `SCRB_ADDR_CONF && reg_rd_from_eeprom)) begin
            next_r.ee_req = 1'b1;
            next_r.ee_addr = {4'h0, reg_addr[2:0]};
            next_r.state = SCRB_RD_WAIT;
          end else begin
            next_r.rvalid = 1'b1;
            next_r.rdata = (reg_addr == `SCRB_ADDR_CONF) ? conf_view : 16'h0000;
          end
        end
      end
      SCRB_RD_WAIT: begin
        if (ee_rvalid) begin
          next_r.rvalid = 1'b1;
          next_r.rdata = ee_rdata;
          next_r.state = SCRB_IDLE;
        end
      end
      default: begin
        next_r.state = SCRB_IDLE;
      end
    endcase

    // unlock sequence: protection off while in test mode arms the clear
    if (r.test_mode && r.wr_allowed) begin
      next_r.armed = 1'b1;
    end
    if (!next_r.test_mode) begin
      next_r.armed = 1'b0;
    end
    if (r.test_mode && !next_r.test_mode && (r.armed || r.wr_allowed)) begin
      next_r.fatal = 1'b0;
    end
    // a fault in the same cycle as the clear still sets the flag
    if (err_hit) begin
      next_r.fatal = 1'b1;
    end

    // registered derived outputs
    next_r.relay_threshold = live[3][`SCRB_THR_SRC_BIT] ? pot_threshold : next_r.stored_threshold;
    next_r.dac_ref_mv = dac_mv(live[1][`SCRB_DAC_REF_MSB:`SCRB_DAC_REF_LSB]);
  end

  // state register
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      r <= '{
        state: SCRB_BOOT_REQ,
        boot_idx: 3'h0,
        test_mode: 1'b0,
        wr_allowed: 1'b0,
        fatal: 1'b0,
        armed: 1'b0,
        rdata: 16'h0000,
        rvalid: 1'b0,
        ee_req: 1'b0,
        ee_we: 1'b0,
        ee_addr: 7'h00,
        ee_wdata: 16'h0000,
        stored_threshold: 16'h0000,
        relay_threshold: 16'h0000,
        dac_ref_mv: 13'h0000
      };
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////

  // host and eeprom ports
  assign reg_busy = (r.state != SCRB_IDLE);
  assign reg_rdata = r.rdata;
  assign reg_rvalid = r.rvalid;
  assign ee_req = r.ee_req;
  assign ee_we = r.ee_we;
  assign ee_addr = r.ee_addr;
  assign ee_wdata = r.ee_wdata;

  // ir chain gain word
  assign reference_halve_enable = live[0][`SCRB_HALVE_BIT];
  assign dac_regulator_enable = live[0][`SCRB_DAC_EN_BIT];
  assign low_noise_enable = live[0][`SCRB_LOW_NOISE_BIT];
  assign ir_gain_code = live[0][`SCRB_IR_GAIN_MSB:`SCRB_IR_GAIN_LSB];

  // ir chain reference word
  assign reserved_ground_bits = live[1][`SCRB_GND_RSV_MSB:`SCRB_GND_RSV_LSB];
  assign dac_reference_select = live[1][`SCRB_DAC_REF_MSB:`SCRB_DAC_REF_LSB];
  assign dac_reference_mv = r.dac_ref_mv;
  assign ir_ground_level_select = {ir_ground_level_msb, live[1][`SCRB_GND_LVL_MSB:`SCRB_GND_LVL_LSB]};

  // temperature chain word
  assign ambient_reference_select = live[2][`SCRB_AMB_REF_MSB:`SCRB_AMB_REF_LSB];
  assign mirror_ratio_select = live[2][`SCRB_MIRROR_MSB:`SCRB_MIRROR_LSB];
  assign temp_gain_code = live[2][`SCRB_TEMP_GAIN_MSB:`SCRB_TEMP_GAIN_LSB];

  // general configuration word
  assign internal_reference_stop = live[3][`SCRB_REF_STOP_BIT];
  assign vref_pin_input = ~live[0][`SCRB_DAC_EN_BIT];
  assign battery_regulator_enable = live[3][`SCRB_BATT_REG_BIT];
  assign adc_reference_source = live[3][`SCRB_ADC_REF_BIT];
  assign threshold_source_select = live[3][`SCRB_THR_SRC_BIT];
  assign relay_threshold = r.relay_threshold;
  assign comparator_target_select = live[3][`SCRB_CMP_TGT_BIT];
  assign comparator_polarity = live[3][`SCRB_CMP_POL_BIT];
  assign temp_chain_bypass = live[3][`SCRB_BYPASS_BIT];
  assign relay_target_select = live[3][`SCRB_REL_TGT_BIT];
  assign relay_polarity = live[3][`SCRB_REL_POL_BIT];
  assign eeprom_write_allowed_flag = r.wr_allowed;
  assign test_mode_flag = r.test_mode;
  assign fatal_error_flag = r.fatal;

endmodule
`default_nettype wire

// [logic/scrb_word_reg.sv]
`timescale 1ns/10ps
`default_nettype none
`include "scrb_params.svh"

module scrb_word_reg #(
  parameter logic [15:0] RESET_VALUE = `SCRB_WORD_RESET,
  parameter logic [15:0] WRITE_MASK = `SCRB_WORD_MASK
) (
  input wire logic clk_sys, // system clock
  input wire logic rst_b, // async reset, active low
  input wire logic load, // boot copy from eeprom
  input wire scrb_pkg::scrb_word_type load_data, // eeprom word
  input wire logic wr, // host write in test mode
  input wire scrb_pkg::scrb_word_type wr_data, // host data
  output scrb_pkg::scrb_word_type word // live word
);
  import scrb_pkg::*;

  scrb_word_state_type r;
  scrb_word_state_type next_r;
  scrb_word_type src;

  // masked update, protected bits keep their value
  always_comb begin
    next_r = r;
    src = load ? load_data : wr_data;
    if (load || wr) begin
      next_r.word = (r.word & ~WRITE_MASK) | (src & WRITE_MASK);
    end
  end

  // state register
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      r <= '{word: RESET_VALUE};
    end else begin
      r <= next_r;
    end
  end

  assign word = r.word;

endmodule
`default_nettype wire

// [tb/scrb_assertions.sv]
`timescale 1ns/10ps
`default_nettype none
module scrb_assertions (
  input wire logic clk_sys, // clock
  input wire logic rst_b, // reset
  input wire logic [4:0] reg_addr, // address
  input wire logic reg_wr, // write
  input wire logic reg_rd, // read
  input wire scrb_pkg::scrb_word_type reg_wdata, // data
  input wire logic reg_busy, // busy
  input wire logic ee_req, // request
  input wire logic ee_we, // write
  input wire logic [6:0] ee_addr, // address
  input wire logic test_mode_flag, // test
  input wire logic eeprom_write_allowed_flag, // unlocked
  input wire logic fatal_error_flag // fault
);
  import scrb_pkg::*;
  // accepted strobes by target
  wire wr = reg_wr & !reg_busy;
  wire rd = reg_rd & !reg_wr & !reg_busy;
  wire key = wr & reg_addr == 5'h10;
  wire wp = wr & reg_addr[4:3] == 2'b11;
  wire cw = wr & reg_addr < 5'h04;
  wire leave = key & test_mode_flag & reg_wdata != 16'hb200;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////
  boot_read_a: assert property ($rose(rst_b) |=> ee_req && !ee_we && ee_addr == 7'h00)
    else $error("boot read missing");
  copy_read_a: assert property (rd && reg_addr < 5'h03 |=> ee_req && !ee_we && ee_addr == {2'b00, $past(reg_addr)})
    else $error("read not from copy");
  live_keep_a: assert property (cw && !test_mode_flag |=> !ee_req)
    else $error("write outside test mode");
  ee_gate_a: assert property (cw && test_mode_flag |=> (ee_req && ee_we) == $past(eeprom_write_allowed_flag))
    else $error("eeprom write gate wrong");
  test_key_a: assert property (key |=> test_mode_flag == ($past(reg_wdata) == 16'hb200))
    else $error("test key wrong");
  wp_key_a: assert property (wp |=> eeprom_write_allowed_flag == ($past(reg_wdata) == 16'h0065))
    else $error("protect key wrong");
  flags_hold_a: assert property (!key && !wp |=> $stable({test_mode_flag, eeprom_write_allowed_flag}))
    else $error("flag moved");
  fatal_clear_a: assert property ($fell(fatal_error_flag) |-> $past(leave))
    else $error("fatal cleared early");
endmodule
bind scrb_register_bank scrb_assertions scrb_assertions_inst (.clk_sys, .rst_b, .reg_addr, .reg_wr, .reg_rd,
  .reg_wdata, .reg_busy, .ee_req, .ee_we, .ee_addr, .test_mode_flag, .eeprom_write_allowed_flag, .fatal_error_flag);
`default_nettype wire

// [tb/scrb_eeprom_model.sv]
`timescale 1ns/10ps
`default_nettype none
module scrb_eeprom_model (
  input wire logic clk_sys, // clock
  input wire logic rst_b, // reset
  input wire logic ee_req, // request
  input wire logic ee_we, // write
  input wire logic [6:0] ee_addr, // address
  input wire scrb_pkg::scrb_word_type ee_wdata, // write data
  input wire logic [3:0] lat, // read delay
  input wire logic bad, // report fault
  output scrb_pkg::scrb_word_type ee_rdata, // read data
  output logic ee_rvalid, // answer
  output logic ee_multi_err // fault
);
  import scrb_pkg::*;
  scrb_word_type mem [0:127];
  logic [6:0] ra;
  logic [3:0] cnt;
  logic pend;
  // store writes, answer reads lat+1 cycles after the request
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pend <= 1'b0;
      ee_rvalid <= 1'b0;
      ee_multi_err <= 1'b0;
      ee_rdata <= 16'h0000;
    end else begin
      ee_rvalid <= 1'b0;
      ee_multi_err <= 1'b0;
      ee_rdata <= ~ee_rdata; // idle bus keeps moving
      if (ee_req && ee_we) begin
        mem[ee_addr] <= ee_wdata;
      end
      if (ee_req && !ee_we) begin
        pend <= 1'b1;
        cnt <= lat;
        ra <= ee_addr;
      end else if (pend && cnt == 4'h0) begin
        pend <= 1'b0;
        ee_rvalid <= 1'b1;
        ee_multi_err <= bad;
        ee_rdata <= mem[ra];
      end else if (pend) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// [tb/scrb_register_bank_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module scrb_register_bank_tb;
  import scrb_pkg::*;
  localparam scrb_word_type E0 = 16'hd5a0, E1 = 16'h3b40, E2 = 16'h9da0, E3 = 16'h5540;
  logic clk_sys = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, reg_rd_from_eeprom = 0, ir_ground_level_msb = 0, bad = 0;
  logic [4:0] reg_addr = 5'h00;
  logic [3:0] lat = 4'h0;
  scrb_word_type reg_wdata = 16'h0000, pot_threshold = 16'hbeef;
  wire scrb_word_type reg_rdata, ee_wdata, ee_rdata, rthr;
  wire reg_busy, reg_rvalid, ee_req, ee_we, ee_rvalid, ee_multi_err, vin;
  wire [6:0] ee_addr;
  wire [15:0] w0, w1, w2, w3;
  wire [12:0] mv;
  wire [4:0] gnd;
  int failures = 0, tests_run = 0, cyc = 0;
  always #4 clk_sys = ~clk_sys;
  scrb_register_bank scrb_register_bank_inst (.clk_sys, .rst_b, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
    .reg_rd_from_eeprom, .reg_busy, .reg_rdata, .reg_rvalid, .ee_req, .ee_we, .ee_addr, .ee_wdata, .ee_rdata,
    .ee_rvalid, .ee_multi_err, .ir_ground_level_msb, .pot_threshold, .reference_halve_enable(w0[15]),
    .dac_regulator_enable(w0[14]), .low_noise_enable(w0[13]), .ir_gain_code(w0[12:5]),
    .reserved_ground_bits(w1[15:12]), .dac_reference_select(w1[11:9]), .dac_reference_mv(mv),
    .ir_ground_level_select(gnd), .ambient_reference_select(w2[15:14]), .mirror_ratio_select(w2[13:11]),
    .temp_gain_code(w2[10:5]), .internal_reference_stop(w3[14]), .vref_pin_input(vin),
    .battery_regulator_enable(w3[13]), .adc_reference_source(w3[12]), .threshold_source_select(w3[11]),
    .relay_threshold(rthr), .comparator_target_select(w3[10]), .comparator_polarity(w3[9]),
    .temp_chain_bypass(w3[8]), .relay_target_select(w3[7]), .relay_polarity(w3[6]),
    .eeprom_write_allowed_flag(w3[5]), .test_mode_flag(w3[4]), .fatal_error_flag(w3[15]));
  scrb_eeprom_model scrb_eeprom_model_inst (.clk_sys, .rst_b, .ee_req, .ee_we, .ee_addr, .ee_wdata, .lat, .bad,
    .ee_rdata, .ee_rvalid, .ee_multi_err);
  ////////////////////////////////////////
  // compare and count
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", n, e, g);
      failures++;
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      report_and_stop();
    end
  end
  // one write strobe, then one settling cycle
  task automatic wr(input logic [4:0] a, input scrb_word_type d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    @(negedge clk_sys);
  endtask
  // one read, bounded wait for the answer
  task automatic rd(input logic [4:0] a, input logic s, input scrb_word_type e);
    int n = 0;
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd_from_eeprom = s;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    while (reg_rvalid !== 1'b1 && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    chk("read", e, reg_rvalid === 1'b1 ? reg_rdata : 16'hxxxx);
  endtask
  ////////////////////////////////////////
  task automatic t_boot;
    chk("word0", E0, {w0[15:5], 5'h00});
    chk("word1", E1, {w1[15:9], gnd[3:0], 5'h00});
    chk("word2", E2, {w2[15:5], 5'h00});
    chk("word3", E3, {w3[15:4], 4'h0});
    chk("thr", 16'h0123, rthr);
    $display("done boot");
  endtask
  task automatic t_test;
    wr(5'h10, 16'hb201);
    chk("test", 16'h0000, {15'h0, w3[4]});
    wr(5'h10, 16'hb200);
    chk("test", 16'h0001, {15'h0, w3[4]});
    wr(5'h00, 16'h0000);
    chk("word0", 16'h0000, {w0[15:5], 5'h00});
    chk("vref in", 16'h0001, {15'h0, vin});
    rd(5'h00, 1'b0, E0);
    rd(5'h03, 1'b0, E3 | 16'h0010);
    rd(5'h03, 1'b1, E3);
    $display("done test");
  endtask
  task automatic t_unlock;
    wr(5'h03, 16'h0000);
    rd(5'h03, 1'b0, 16'h0010);
    wr(5'h1f, 16'h0065);
    chk("unlock", 16'h0001, {15'h0, w3[5]});
    wr(5'h00, 16'h8000);
    chk("halve", 16'h0001, {15'h0, w0[15]});
    for (int c = 0; c < 6; c++) begin
      wr(5'h01, {4'h0, c[2:0], 9'h000});
      chk("mv", 16'(2000 + 500 * c), {3'h0, mv});
    end
    rd(5'h01, 1'b0, 16'h0a00);
    $display("done unlock");
  endtask
  task automatic t_lock;
    wr(5'h10, 16'h0000);
    wr(5'h02, 16'hffe0);
    chk("word2", E2, {w2[15:5], 5'h00});
    rd(5'h02, 1'b0, E2);
    $display("done lock");
  endtask
  task automatic t_fatal;
    lat = 4'h5;
    bad = 1'b1;
    rd(5'h02, 1'b0, E2);
    bad = 1'b0;
    chk("fatal", 16'h0001, {15'h0, w3[15]});
    wr(5'h18, 16'h0000);
    wr(5'h10, 16'hb200);
    wr(5'h10, 16'h0000);
    chk("fatal", 16'h0001, {15'h0, w3[15]});
    wr(5'h10, 16'hb200);
    wr(5'h18, 16'h0065);
    wr(5'h10, 16'h0000);
    chk("fatal", 16'h0000, {15'h0, w3[15]});
    $display("done fatal");
  endtask
  task automatic t_thr;
    lat = 4'h0;
    ir_ground_level_msb = 1'b1;
    wr(5'h10, 16'hb200);
    wr(5'h03, 16'h4fc0);
    chk("word3", 16'h4ff0, {w3[15:4], 4'h0});
    chk("thr", 16'hbeef, rthr);
    chk("gnd", 16'h0010, {11'h0, gnd[4], 4'h0});
    wr(5'h03, 16'h0000);
    chk("thr", 16'h0123, rthr);
    $display("done thr");
  endtask
  initial begin
    scrb_eeprom_model_inst.mem[7'h00] = E0;
    scrb_eeprom_model_inst.mem[7'h01] = E1;
    scrb_eeprom_model_inst.mem[7'h02] = E2;
    scrb_eeprom_model_inst.mem[7'h03] = E3;
    scrb_eeprom_model_inst.mem[7'h75] = 16'h0123;
    repeat (20) @(negedge clk_sys);
    chk("reset conf", 16'h2000, {w3[15:4], 4'h0});
    rst_b = 1'b1;
    repeat (40) @(negedge clk_sys);
    chk("busy", 16'h0000, {15'h0, reg_busy});
    t_boot();
    t_test();
    t_unlock();
    t_lock();
    t_fatal();
    t_thr();
    report_and_stop();
  end
endmodule
`default_nettype wire
